// >>> hw/rds_pkg.sv
//==============================================================================
//==============================================================================
package rds_pkg;
  localparam int         REG_AW      = 5;
  localparam logic [4:0] LAST_REG    = 5'h1d;
  localparam logic [1:0] SUBADDR_CODE = 2'h1;
  localparam int         CMD_RW_BIT   = 7;
  localparam int         SUBADDR_MSB  = 6;
  localparam int         SUBADDR_LSB  = 5;
  localparam logic [6:0] DEV_ADDR    = 7'h51;
  // Pin image {strap, select_n, clock, serial_in, data}
  localparam logic [4:0] DEV_PIN_RST = 5'h09;
  localparam logic [1:0] HOST_IN_RST = 2'h3;
  localparam int         MCLK_PERIOD_NS = 4;
  localparam int         LINK_PERIOD_NS = 32;
  localparam int         HALF_CYC =
    (LINK_PERIOD_NS + 2 * MCLK_PERIOD_NS - 1) / (2 * MCLK_PERIOD_NS);
  localparam logic [3:0] LAST_BIT_SPI = 4'h7;
  localparam logic [3:0] LAST_BIT_TW  = 4'h8;

  function automatic logic [4:0] nextPtr(input logic [4:0] p);
    return (p >= LAST_REG) ? 5'h00 : p + 5'h01;
  endfunction
endpackage

// >>> hw/rds_if.sv
`timescale 1ns/100ps
//==============================================================================
// Link wires; the data line is open drain with a pull-up
interface rds_if;
  logic linkSelStrap;
  logic ceN;
  logic sclk;
  logic serialIn;
  logic serialOut;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sda;

  assign sda = !(hostSdaOe && !hostSdaOut) && !(devSdaOe && !devSdaOut);

  modport device (input linkSelStrap, ceN, sclk, serialIn, sda,
                  output serialOut, devSdaOut, devSdaOe);
  modport host (output linkSelStrap, ceN, sclk, serialIn, hostSdaOut, hostSdaOe,
                input serialOut, sda);
endinterface

// >>> hw/rds_device.sv
`timescale 1ns/100ps
//==============================================================================
// Device end: serial slave front end with a register access port
module rds_device (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  rds_if.device                           link,
  output logic [rds_pkg::REG_AW-1:0]      regAddr,
  output logic [7:0]                      regWrData,
  output logic                            regWrEn,
  input  wire logic [7:0]                 regRdData,
  output logic                            twoWireMode
);
  import rds_pkg::*;

  typedef enum logic [6:0] {
    I_IDLE = 7'b0000001,
    I_ADDR = 7'b0000010,
    I_ACKA = 7'b0000100,
    I_RX   = 7'b0001000,
    I_ACKW = 7'b0010000,
    I_TX   = 7'b0100000,
    I_MACK = 7'b1000000
  } rds_tw_e;

  //============================================================================
  // Pin synchronisers and edge finders
  logic [4:0] meta_q;
  logic [4:0] pin_q;
  logic [4:0] old_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= DEV_PIN_RST;
      pin_q  <= DEV_PIN_RST;
      old_q  <= DEV_PIN_RST;
    end else begin
      meta_q <= {link.linkSelStrap, link.ceN, link.sclk, link.serialIn, link.sda};
      pin_q  <= meta_q;
      old_q  <= pin_q;
    end
  end

  logic twSel;
  logic spiActive;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  assign twoWireMode = pin_q[4];
  assign twSel       = pin_q[4];
  assign spiActive   = !pin_q[4] && !pin_q[3];
  assign sclRise     = pin_q[2] && !old_q[2];
  assign sclFall     = !pin_q[2] && old_q[2];
  // Clock must be high in both samples so a data edge beside a clock edge is no marker
  assign startCond   = twSel && pin_q[2] && old_q[2] && !pin_q[0] && old_q[0];
  assign stopCond    = twSel && pin_q[2] && old_q[2] && pin_q[0] && !old_q[0];

  //============================================================================
  // Four-wire serial slave
  logic [2:0] spiCnt_q;
  logic       spiCmdDone_q;
  logic       spiRead_q;
  logic       spiValid_q;
  logic [7:0] spiSh_q;
  logic [7:0] spiTx_q;
  logic       serialOut_q;
  logic [7:0] spiByte;
  logic       spiCmdEnd;
  logic       spiWrByte;
  logic       spiRdLoad;

  assign spiByte   = {spiSh_q[6:0], pin_q[1]};
  assign spiCmdEnd = spiActive && sclRise && spiCnt_q == 3'h7 && !spiCmdDone_q;
  assign spiWrByte = spiActive && sclRise && spiCnt_q == 3'h7 && spiCmdDone_q
                     && !spiRead_q && spiValid_q;
  assign spiRdLoad = spiActive && sclFall && spiCnt_q == 3'h0 && spiCmdDone_q
                     && spiRead_q && spiValid_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spiCnt_q     <= 3'h0;
      spiCmdDone_q <= 1'b0;
      spiRead_q    <= 1'b0;
      spiValid_q   <= 1'b0;
      spiSh_q      <= 8'h00;
      spiTx_q      <= 8'h00;
      serialOut_q  <= 1'b0;
    end else if (!spiActive) begin
      spiCnt_q     <= 3'h0;
      spiCmdDone_q <= 1'b0;
      spiRead_q    <= 1'b0;
      spiValid_q   <= 1'b0;
      spiSh_q      <= 8'h00;
      spiTx_q      <= 8'h00;
      serialOut_q  <= 1'b0;
    end else begin
      if (sclRise) begin
        spiSh_q  <= spiByte;
        spiCnt_q <= spiCnt_q + 3'h1;
      end
      if (spiCmdEnd) begin
        spiCmdDone_q <= 1'b1;
        spiRead_q    <= spiByte[CMD_RW_BIT];
        spiValid_q   <= spiByte[SUBADDR_MSB:SUBADDR_LSB] == SUBADDR_CODE;
      end
      // Output moves only on falling edges; first bit of each byte loads fresh data
      if (sclFall && spiCmdDone_q && spiRead_q && spiValid_q) begin
        if (spiCnt_q == 3'h0) begin
          spiTx_q     <= regRdData;
          serialOut_q <= regRdData[7];
        end else begin
          spiTx_q     <= {spiTx_q[6:0], 1'b0};
          serialOut_q <= spiTx_q[6];
        end
      end
    end
  end

  assign link.serialOut = serialOut_q;

  //============================================================================
  // Two-wire slave
  rds_tw_e    twState_q;
  logic [3:0] twCnt_q;
  logic [7:0] twSh_q;
  logic [7:0] twTx_q;
  logic       twRead_q;
  logic       twFirst_q;
  logic       twMAck_q;
  logic       sdaOe_q;
  logic       twRdLoad;
  logic       twRxEnd;

  assign twRdLoad = twSel && sclFall && ((twState_q == I_ACKA && twRead_q) ||
                    (twState_q == I_MACK && twMAck_q));
  assign twRxEnd  = twSel && sclFall && twState_q == I_RX && twCnt_q == 4'h8;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      twState_q <= I_IDLE;
      twCnt_q   <= 4'h0;
      twSh_q    <= 8'h00;
      twTx_q    <= 8'h00;
      twRead_q  <= 1'b0;
      twFirst_q <= 1'b0;
      twMAck_q  <= 1'b0;
      sdaOe_q   <= 1'b0;
    end else if (!twSel) begin
      twState_q <= I_IDLE;
      twCnt_q   <= 4'h0;
      sdaOe_q   <= 1'b0;
    end else if (startCond) begin
      twState_q <= I_ADDR;
      twCnt_q   <= 4'h0;
      sdaOe_q   <= 1'b0;
    end else if (stopCond) begin
      twState_q <= I_IDLE;
      sdaOe_q   <= 1'b0;
    end else begin
      case (twState_q)
        I_ADDR, I_RX: begin
          if (sclRise) begin
            twSh_q  <= {twSh_q[6:0], pin_q[0]};
            twCnt_q <= twCnt_q + 4'h1;
          end else if (sclFall && twCnt_q == 4'h8) begin
            twCnt_q <= 4'h0;
            if (twState_q == I_RX) begin
              sdaOe_q   <= 1'b1;
              twFirst_q <= 1'b0;
              twState_q <= I_ACKW;
            end else if (twSh_q[7:1] == DEV_ADDR) begin
              twRead_q  <= twSh_q[0];
              twFirst_q <= 1'b1;
              sdaOe_q   <= 1'b1;
              twState_q <= I_ACKA;
            end else begin
              twState_q <= I_IDLE;
            end
          end
        end
        I_ACKA, I_MACK: begin
          if (twState_q == I_MACK && sclRise) begin
            twMAck_q <= !pin_q[0];
          end else if (sclFall) begin
            if (twRdLoad) begin
              twTx_q    <= regRdData;
              sdaOe_q   <= !regRdData[7];
              twCnt_q   <= 4'h1;
              twState_q <= I_TX;
            end else if (twState_q == I_ACKA) begin
              sdaOe_q   <= 1'b0;
              twState_q <= I_RX;
            end else begin
              sdaOe_q   <= 1'b0;
              twState_q <= I_IDLE;
            end
          end
        end
        I_ACKW: begin
          if (sclFall) begin
            sdaOe_q   <= 1'b0;
            twState_q <= I_RX;
          end
        end
        I_TX: begin
          if (sclFall) begin
            if (twCnt_q == 4'h8) begin
              // Let go for the master's acknowledge slot
              sdaOe_q   <= 1'b0;
              twMAck_q  <= 1'b0;
              twCnt_q   <= 4'h0;
              twState_q <= I_MACK;
            end else begin
              sdaOe_q <= !twTx_q[6];
              twTx_q  <= {twTx_q[6:0], 1'b0};
              twCnt_q <= twCnt_q + 4'h1;
            end
          end
        end
        default: begin
          twState_q <= I_IDLE;
          sdaOe_q   <= 1'b0;
        end
      endcase
    end
  end

  assign link.devSdaOe  = sdaOe_q;
  assign link.devSdaOut = 1'b0;

  //============================================================================
  // Shared register pointer and write strobe
  logic [4:0] ptr_q;
  logic [7:0] wrData_q;
  logic       wrEn_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrEn_q   <= 1'b0;
      wrData_q <= 8'h00;
    end else begin
      wrEn_q <= spiWrByte || (twRxEnd && !twFirst_q);
      if (spiWrByte) begin
        wrData_q <= spiByte;
      end else if (twRxEnd && !twFirst_q) begin
        wrData_q <= twSh_q;
      end
    end
  end

  // Pointer steps one cycle after a write strobe so address and data stand together
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 5'h00;
    end else if (spiCmdEnd) begin
      ptr_q <= spiByte[4:0];
    end else if (twRxEnd && twFirst_q) begin
      ptr_q <= twSh_q[4:0];
    end else if (spiRdLoad || twRdLoad || wrEn_q) begin
      ptr_q <= nextPtr(ptr_q);
    end
  end

  assign regAddr   = ptr_q;
  assign regWrData = wrData_q;
  assign regWrEn   = wrEn_q;
endmodule // rds_device

// >>> hw/rds_host.sv
`timescale 1ns/100ps
//==============================================================================
// Host end: single register read or write over either link
module rds_host (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  rds_if.host                             link,
  input  wire logic                       useTwoWire,
  input  wire logic                       req,
  input  wire logic                       reqRead,
  input  wire logic [rds_pkg::REG_AW-1:0] reqAddr,
  input  wire logic [7:0]                 reqData,
  output logic                            busy,
  output logic                            done,
  output logic [7:0]                      rdData,
  output logic                            nackSeen
);
  import rds_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE   = 7'b0000001,
    H_START1 = 7'b0000010,
    H_START2 = 7'b0000100,
    H_LOW    = 7'b0001000,
    H_HIGH   = 7'b0010000,
    H_STOP1  = 7'b0100000,
    H_STOP2  = 7'b1000000
  } rds_host_e;

  //============================================================================
  // Divider and input synchronisers
  logic [3:0] div_q;
  logic       tick;
  logic [1:0] meta_q;
  logic [1:0] pin_q;

  assign tick = div_q == 4'(HALF_CYC - 1);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 4'h0;
      meta_q <= HOST_IN_RST;
      pin_q  <= HOST_IN_RST;
    end else begin
      div_q  <= tick ? 4'h0 : div_q + 4'h1;
      meta_q <= {link.serialOut, link.sda};
      pin_q  <= meta_q;
    end
  end

  //============================================================================
  // Byte sequencer
  rds_host_e  st_q;
  logic       tw_q;
  logic       rw_q;
  logic [4:0] addr_q;
  logic [7:0] data_q;
  logic [1:0] idx_q;
  logic [3:0] bit_q;
  logic [7:0] rx_q;
  logic       restart_q;
  logic       strap_q;
  logic       ceN_q;
  logic       sclk_q;
  logic       mosi_q;
  logic       sdaOe_q;
  logic       busy_q;
  logic       done_q;
  logic       nack_q;
  logic [7:0] rdData_q;
  logic [7:0] txByte;
  logic       bitVal;
  logic       din;
  logic [3:0] lastBit;
  logic [1:0] lastIdx;

  always_comb begin
    txByte = 8'hff;
    case ({tw_q, idx_q})
      3'h0: txByte = {rw_q, SUBADDR_CODE, addr_q};
      3'h1: txByte = rw_q ? 8'hff : data_q;
      3'h4: txByte = {DEV_ADDR, 1'b0};
      3'h5: txByte = {3'h0, addr_q};
      3'h6: txByte = rw_q ? {DEV_ADDR, 1'b1} : data_q;
      // The only read byte is also the last, so its ack slot stays released
      default: txByte = 8'hff;
    endcase
  end

  // Ack slots and read bytes are released; a lone read byte is not acknowledged
  assign bitVal  = (bit_q < 4'h8) ? txByte[3'h7 - bit_q[2:0]] : 1'b1;
  assign din     = tw_q ? pin_q[0] : pin_q[1];
  assign lastBit = tw_q ? LAST_BIT_TW : LAST_BIT_SPI;
  assign lastIdx = tw_q ? (rw_q ? 2'h3 : 2'h2) : 2'h1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= H_IDLE;
      tw_q      <= 1'b0;
      rw_q      <= 1'b0;
      addr_q    <= 5'h00;
      data_q    <= 8'h00;
      idx_q     <= 2'h0;
      bit_q     <= 4'h0;
      rx_q      <= 8'h00;
      restart_q <= 1'b0;
      strap_q   <= 1'b0;
      ceN_q     <= 1'b1;
      sclk_q    <= 1'b0;
      mosi_q    <= 1'b0;
      sdaOe_q   <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      nack_q    <= 1'b0;
      rdData_q  <= 8'h00;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          strap_q <= useTwoWire;
          tw_q    <= useTwoWire;
          sclk_q  <= useTwoWire;
          if (req) begin
            rw_q   <= reqRead;
            addr_q <= reqAddr;
            data_q <= reqData;
            idx_q  <= 2'h0;
            bit_q  <= 4'h0;
            nack_q <= 1'b0;
            busy_q <= 1'b1;
            st_q   <= H_START1;
          end
        end
        H_START1: if (tick) begin
          sdaOe_q <= tw_q;
          ceN_q   <= tw_q;
          st_q    <= H_START2;
        end
        H_START2: if (tick) begin
          sclk_q <= 1'b0;
          st_q   <= H_LOW;
        end
        H_LOW: begin
          // Data moves a cycle after the clock falls, never while it is high
          mosi_q  <= bitVal;
          sdaOe_q <= tw_q && !bitVal;
          if (tick) begin
            sclk_q <= 1'b1;
            st_q   <= H_HIGH;
          end
        end
        H_HIGH: if (tick) begin
          sclk_q <= 1'b0;
          if (bit_q < 4'h8) begin
            rx_q <= {rx_q[6:0], din};
          end else if (!(rw_q && idx_q == 2'h3) && din) begin
            nack_q <= 1'b1;
          end
          if (bit_q == lastBit) begin
            bit_q <= 4'h0;
            if (idx_q == lastIdx) begin
              st_q <= H_STOP1;
            end else if (tw_q && rw_q && idx_q == 2'h1) begin
              restart_q <= 1'b1;
              st_q      <= H_STOP1;
            end else begin
              idx_q <= idx_q + 2'h1;
              st_q  <= H_LOW;
            end
          end else begin
            bit_q <= bit_q + 4'h1;
            st_q  <= H_LOW;
          end
        end
        H_STOP1: begin
          sdaOe_q <= tw_q;
          if (tick) begin
            sclk_q <= tw_q;
            st_q   <= H_STOP2;
          end
        end
        H_STOP2: if (tick) begin
          sdaOe_q <= 1'b0;
          ceN_q   <= 1'b1;
          if (restart_q) begin
            restart_q <= 1'b0;
            idx_q     <= idx_q + 2'h1;
            st_q      <= H_START1;
          end else begin
            busy_q   <= 1'b0;
            done_q   <= 1'b1;
            rdData_q <= rw_q ? rx_q : rdData_q;
            st_q     <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.linkSelStrap = strap_q;
  assign link.ceN          = ceN_q;
  assign link.sclk         = sclk_q;
  assign link.serialIn     = mosi_q;
  assign link.hostSdaOe    = sdaOe_q;
  assign link.hostSdaOut   = 1'b0;
  assign busy              = busy_q;
  assign done              = done_q;
  assign rdData            = rdData_q;
  assign nackSeen          = nack_q;
endmodule // rds_host

// >>> sim/rds_link_asserts.sv
`timescale 1ns/100ps
//==============================================================================
// Link checker, instantiated beside the interface
module rds_link_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic linkSelStrap,
  input wire logic ceN,
  input wire logic sclk,
  input wire logic serialOut,
  input wire logic devSdaOe,
  input wire logic sda
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic       sclk_q;
  logic [3:0] sinceFall_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  // Saturating count of cycles since the link clock last fell
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) sinceFall_q <= 4'hf;
    else if (sclk_q && !sclk) sinceFall_q <= 4'h0;
    else if (sinceFall_q != 4'hf) sinceFall_q <= sinceFall_q + 4'h1;
  end

  property p_outIdle;
    ceN [*5] |-> serialOut == 1'b0;
  endproperty
  a_outIdle: assert property (p_outIdle) else $error("serial out not low while deselected");

  property p_outOnFall;
    $changed(serialOut) |-> ceN || sinceFall_q <= 4'h5;
  endproperty
  a_outOnFall: assert property (p_outOnFall) else $error("serial out moved away from a falling edge");

  property p_cmdFirst;
    $fell(ceN) |-> serialOut == 1'b0 [*8];
  endproperty
  a_cmdFirst: assert property (p_cmdFirst) else $error("serial out active during command byte");

  property p_ackHold;
    $rose(devSdaOe) |-> devSdaOe [*5];
  endproperty
  a_ackHold: assert property (p_ackHold) else $error("data pull released too early");

  property p_sdaOnLow;
    $changed(devSdaOe) |-> !sclk;
  endproperty
  a_sdaOnLow: assert property (p_sdaOnLow) else $error("device moved data while clock high");

  property p_noSdaInSpi;
    !linkSelStrap [*5] |-> !devSdaOe;
  endproperty
  a_noSdaInSpi: assert property (p_noSdaInSpi) else $error("data pulled in four-wire mode");

  property p_noOutInTw;
    linkSelStrap [*5] |-> serialOut == 1'b0;
  endproperty
  a_noOutInTw: assert property (p_noOutInTw) else $error("serial out active in two-wire mode");

  property p_stopIdle;
    ($rose(sda) && sclk && $past(sclk)) |=> !devSdaOe [*8];
  endproperty
  a_stopIdle: assert property (p_stopIdle) else $error("data pulled after stop");

  c_ack: cover property ($rose(devSdaOe));
  c_sel: cover property ($fell(ceN));
  c_out: cover property ($changed(serialOut));
endmodule // rds_link_asserts

// >>> sim/rds_tb_top.sv
`timescale 1ns/100ps
//==============================================================================
// Both ends face each other; the bench owns the register array
module rds_tb_top;
  import rds_pkg::*;

  logic       mclk;
  logic       rst_n;
  logic       useTwoWire;
  logic       req;
  logic       reqRead;
  logic [4:0] reqAddr;
  logic [7:0] reqData;
  logic       busy;
  logic       done;
  logic [7:0] rdData;
  logic       nackSeen;
  logic [4:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       twoWireMode;
  logic [7:0] regs [32];
  int         wrCount;
  int         errors;
  int         checked;

  rds_if link ();

  rds_device rds_device_i (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .link        (link),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regWrEn     (regWrEn),
    .regRdData   (regs[regAddr]),
    .twoWireMode (twoWireMode)
  );

  rds_host rds_host_i (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .link       (link),
    .useTwoWire (useTwoWire),
    .req        (req),
    .reqRead    (reqRead),
    .reqAddr    (reqAddr),
    .reqData    (reqData),
    .busy       (busy),
    .done       (done),
    .rdData     (rdData),
    .nackSeen   (nackSeen)
  );

  rds_link_asserts rds_link_asserts_i (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .linkSelStrap (link.linkSelStrap),
    .ceN          (link.ceN),
    .sclk         (link.sclk),
    .serialOut    (link.serialOut),
    .devSdaOe     (link.devSdaOe),
    .sda          (link.sda)
  );

  always #2 mclk = ~mclk;

  // Register array, read combinationally as the device expects
  // Plain always: the initial block clears the same array at time zero
  always @(posedge mclk) begin
    if (regWrEn) begin
      regs[regAddr] <= regWrData;
      wrCount <= wrCount + 1;
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One host transaction; strap settles before the request
  task automatic xfer(input logic tw, input logic rd, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    useTwoWire <= tw;
    repeat (6) @(posedge mclk);
    req     <= 1'b1;
    reqRead <= rd;
    reqAddr <= a;
    reqData <= d;
    @(posedge mclk);
    req <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 3000) begin
      errors++;
      test_done();
    end
  endtask

  logic [4:0] addrTab [3] = '{5'h00, 5'h1d, 5'h0a};
  logic [7:0] dataTab [3] = '{8'ha5, 8'h3c, 8'h81};

  initial begin
    int   wrBefore;
    logic [7:0] d;
    logic [4:0] nxt;
    mclk       = 1'b0;
    rst_n      = 1'b0;
    useTwoWire = 1'b0;
    req        = 1'b0;
    reqRead    = 1'b0;
    reqAddr    = 5'h00;
    reqData    = 8'h00;
    wrCount    = 0;
    errors     = 0;
    checked    = 0;
    for (int i = 0; i < 32; i++) regs[i] = 8'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check("mode", {7'h00, twoWireMode}, 8'h00);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 3; i++) begin
        d        = dataTab[i] ^ (m ? 8'hf0 : 8'h00);
        nxt      = (addrTab[i] == 5'h1d) ? 5'h00 : addrTab[i] + 5'h01;
        wrBefore = wrCount;
        xfer(m[0], 1'b0, addrTab[i], d);
        check("mode", {7'h00, twoWireMode}, {7'h00, m[0]});
        check("written", regs[addrTab[i]], d);
        check("writes", 8'(wrCount - wrBefore), 8'h01);
        check("pointer", {3'h0, regAddr}, {3'h0, nxt});
        check("nack", {7'h00, nackSeen}, 8'h00);
        check("busy", {7'h00, busy}, 8'h00);
        // Read straight after the write, request raised seven cycles after done
        xfer(m[0], 1'b1, addrTab[i], 8'h00);
        check("read", rdData, d);
        check("nowrite", 8'(wrCount - wrBefore), 8'h01);
      end
      $display("test mode %0d finished", m);
    end
    test_done();
  end
endmodule // rds_tb_top
